/* File: core/acc_cal_ctrl.sv */
// Shared ADC core calibration control and status register block
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"
module acc_cal_ctrl #(
  parameter int PWRUP_CYC = `ACC_PWRUP_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [`ACC_AW-1:0]  addr,
  input  wire logic [`ACC_DW-1:0]  wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [`ACC_DW-1:0]  rdata,
  input  wire logic                cal_done,
  output logic                     cal_go,
  output logic                     cal_diff,
  output logic                     cal_busy,
  output logic                     irq
);

  acc_pkg::acc_ctl_t            ctl;
  acc_pkg::acc_state_t          state;
  logic [`ACC_CW-1:0]           wait_cnt;
  logic [`ACC_NEV-1:0]          sts;
  logic [`ACC_NEV-1:0]          msk;
  logic [`ACC_NEV-1:0]          ev;
  logic                         wr_cal;
  logic                         start_req;
  logic                         refuse;
  logic                         done_ev;
  logic                         pwrup_go;
  logic [`ACC_CW-1:0]           since_rst;
  logic [`ACC_DW-1:0]           next_rdata;

  assign wr_cal = wr && (addr == `ACC_A_CAL);

  // Launch request
  assign start_req = wr_cal && ctl.enable && wdata[`ACC_B_START]
                     && (state == acc_pkg::ACC_IDLE);
  assign refuse    = wr_cal && wdata[`ACC_B_START]
                     && !start_req;
  assign done_ev   = (state == acc_pkg::ACC_RUN) && cal_done;
  // Power-up launch: last wait cycle with the bypass clear
  assign pwrup_go  = (state == acc_pkg::ACC_WAIT) && !ctl.bypass
                     && (wait_cnt == PWRUP_CYC[`ACC_CW-1:0] - 1'b1);

  // Calibration sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= acc_pkg::ACC_WAIT;
      wait_cnt <= '0;
    end else begin
      case (state)
        acc_pkg::ACC_WAIT: begin
          if (ctl.bypass) begin
            state <= acc_pkg::ACC_IDLE;
          end else if (wait_cnt == PWRUP_CYC[`ACC_CW-1:0] - 1'b1) begin
            state <= acc_pkg::ACC_RUN;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        acc_pkg::ACC_IDLE: begin
          if (start_req) begin
            state <= acc_pkg::ACC_RUN;
          end
        end
        acc_pkg::ACC_RUN: begin
          if (cal_done) begin
            state <= acc_pkg::ACC_IDLE;
          end
        end
        default: begin
          state <= acc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Pulse to the analog core, one cycle on entry to a run
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_go <= 1'b0;
    end else begin
      cal_go <= start_req || pwrup_go;
    end
  end

  // Mode presented to the analog core, held through a run
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_diff <= 1'b0;
    end else if (state != acc_pkg::ACC_RUN) begin
      cal_diff <= (wr_cal && ctl.enable) ? wdata[`ACC_B_DIFF] : ctl.diff;
    end
  end

  assign cal_busy = (state == acc_pkg::ACC_RUN);

  // Calibration register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= '0;
    end else begin
      if (wr_cal) begin
        ctl.enable <= wdata[`ACC_B_EN];
      end
      if (wr_cal && ctl.enable) begin
        ctl.bypass <= wdata[`ACC_B_BYP];
        if (state != acc_pkg::ACC_RUN) begin
          ctl.diff <= wdata[`ACC_B_DIFF];
        end
      end
      if (start_req) begin
        ctl.start <= 1'b1;
        ctl.ready <= 1'b0;
      end else if (done_ev) begin
        ctl.start <= 1'b0;
        ctl.ready <= 1'b1;
      end
      if (pwrup_go) begin
        ctl.ready <= 1'b0;
      end
    end
  end

  // Interrupt events: completion and refused start
  assign ev[`ACC_EV_DONE]   = done_ev;
  assign ev[`ACC_EV_REFUSE] = refuse;

  genvar gi;
  generate
    for (gi = 0; gi < `ACC_NEV; gi = gi + 1) begin : g_sts
      // Set wins over a write-one clear in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          sts[gi] <= 1'b0;
        end else if (ev[gi]) begin
          sts[gi] <= 1'b1;
        end else if (wr && addr == `ACC_A_STS && wdata[gi]) begin
          sts[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      msk <= '0;
    end else if (wr && addr == `ACC_A_MSK) begin
      msk <= wdata[`ACC_NEV-1:0];
    end
  end

  assign irq = |(sts & msk);

  // Read mux
  always_comb begin
    next_rdata = '0;
    case (addr)
      `ACC_A_CAL: begin
        next_rdata[`ACC_B_EN] = ctl.enable;
        if (ctl.enable) begin
          next_rdata[`ACC_B_RDY]   = ctl.ready;
          next_rdata[`ACC_B_BYP]   = ctl.bypass;
          next_rdata[`ACC_B_DIFF]  = ctl.diff;
          next_rdata[`ACC_B_START] = ctl.start;
        end
      end
      `ACC_A_STS: begin
        next_rdata[`ACC_NEV-1:0] = sts;
      end
      `ACC_A_MSK: begin
        next_rdata[`ACC_NEV-1:0] = msk;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

  // Cycles since reset release, saturating; only the checks read it
  always_ff @(posedge clk) begin
    if (rst) begin
      since_rst <= '0;
    end else if (since_rst != '1) begin
      since_rst <= since_rst + 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  done_clears_start_a: assert property (
    done_ev |=> !ctl.start && ctl.ready)
    else $error("start not cleared or ready not set on completion");

  ready_low_run_a: assert property (
    cal_busy |-> !ctl.ready)
    else $error("ready high while a calibration runs");

  busy_done_a: assert property (
    cal_busy && cal_done |=> !cal_busy && sts[`ACC_EV_DONE])
    else $error("completion did not end the run");

  start_launch_a: assert property (
    start_req |=> cal_go && cal_busy ##1 !cal_go)
    else $error("start write did not launch one pulse");

  busy_refuse_a: assert property (
    wr_cal && wdata[`ACC_B_START] && cal_busy
      |=> !cal_go && sts[`ACC_EV_REFUSE])
    else $error("start accepted during a run");

  diff_launch_a: assert property (
    start_req |=> cal_diff == $past(wdata[`ACC_B_DIFF]))
    else $error("launch did not carry the written mode");

  mode_hold_a: assert property (
    cal_busy && $past(cal_busy) |-> $stable(cal_diff))
    else $error("mode changed during a run");

  read_enabled_a: assert property (
    rd && addr == `ACC_A_CAL && ctl.enable
      |=> rdata[`ACC_B_RDY] == $past(ctl.ready)
          && rdata[`ACC_B_START] == $past(ctl.start))
    else $error("calibration bits unreadable while enabled");

  enable_write_a: assert property (
    wr_cal |=> ctl.enable == $past(wdata[`ACC_B_EN]))
    else $error("access enable bit did not take the write");

  locked_write_a: assert property (
    wr_cal && !ctl.enable && state != acc_pkg::ACC_RUN
      |=> $stable(ctl.bypass) && $stable(ctl.diff) && !cal_go)
    else $error("disabled bits responded to a write");

  read_zero_a: assert property (
    rd && addr == `ACC_A_CAL |=> (rdata & `ACC_CAL_ZERO) == '0)
    else $error("unimplemented bits read nonzero");

  bypass_skip_a: assert property (
    state == acc_pkg::ACC_WAIT && ctl.bypass
      |=> state == acc_pkg::ACC_IDLE && !cal_go)
    else $error("power-up calibration ran while bypassed");

  pwrup_launch_a: assert property (
    pwrup_go |=> cal_go && cal_busy)
    else $error("power-up calibration did not start");

  pwrup_early_a: assert property (
    cal_busy && !ctl.start |-> since_rst >= PWRUP_CYC[`ACC_CW-1:0])
    else $error("power-up calibration started early");

  irq_level_a: assert property (
    done_ev && msk[`ACC_EV_DONE] && !(wr && addr == `ACC_A_MSK) |=> irq)
    else $error("completion did not raise the interrupt");

  rdata_idle_a: assert property (
    !rd |=> rdata == '0)
    else $error("read data stood beyond its cycle");

  sts_clear_a: assert property (
    wr && addr == `ACC_A_STS && wdata[`ACC_EV_DONE] && !done_ev
      |=> !sts[`ACC_EV_DONE])
    else $error("status bit not cleared by a write of one");

  sw_cal_c: cover property (start_req ##[1:20] done_ev);
  pwrup_cal_c: cover property (
    state == acc_pkg::ACC_WAIT ##1 cal_go ##[1:20] done_ev);
  refuse_c: cover property (refuse && cal_busy);
  locked_start_c: cover property (wr_cal && wdata[`ACC_B_START] && !ctl.enable);
  bypass_c: cover property (state == acc_pkg::ACC_WAIT && ctl.bypass);

endmodule
`default_nettype wire

/* File: inc/acc_params.svh */
// Constants for the shared core calibration control block
// Operation
// - Ready flag reads 1 after calibration finishes, 0 while one runs.
// - Writing 1 to the start bit begins a calibration cycle.
// - Hardware clears start bit itself; 0 means next cycle may start. Here start reads 0 but is refused in the power-up wait and run.
// - Mode bit 1 calibrates differential, 0 calibrates single-ended.
// - With access enable 1, software reaches ready, bypass, mode, start.
// - With access enable 0, the calibration bits ignore software.
// - Bits 14 to 12 and 7 to 0 always read zero.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_AW        2
`define ACC_DW        16
`define ACC_A_CAL     2'h0
`define ACC_A_STS     2'h1
`define ACC_A_MSK     2'h2
`define ACC_B_RDY     15
`define ACC_B_BYP     11
`define ACC_B_DIFF    10
`define ACC_B_EN      9
`define ACC_B_START   8
`define ACC_NEV       2
`define ACC_EV_DONE   0
`define ACC_EV_REFUSE 1
`define ACC_PWRUP_CYC 16
`define ACC_CW        16
`define ACC_CAL_ZERO  16'h70ff
`endif

/* File: inc/acc_pkg.sv */
// Types for the shared core calibration control block
package acc_pkg;
  typedef struct packed {
    logic ready;
    logic bypass;
    logic diff;
    logic enable;
    logic start;
  } acc_ctl_t;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_RUN  = 2'b10
  } acc_state_t;
endpackage

/* File: tb/test_acc_cal_ctrl.sv */
// Self-checking bench for the calibration control block
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"
module test_acc_cal_ctrl;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [`ACC_AW-1:0] addr = '0;
  logic [`ACC_DW-1:0] wdata = '0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [`ACC_DW-1:0] rdata;
  logic               cal_done = 1'b0;
  logic               cal_go;
  logic               cal_diff;
  logic               cal_busy;
  logic               irq;
  int                 error_cnt = 0;
  int                 total_checks = 0;

  acc_cal_ctrl #(.PWRUP_CYC(8)) uut (
    .clk      (clk),
    .rst      (rst),
    .addr     (addr),
    .wdata    (wdata),
    .wr       (wr),
    .rd       (rd),
    .rdata    (rdata),
    .cal_done (cal_done),
    .cal_go   (cal_go),
    .cal_diff (cal_diff),
    .cal_busy (cal_busy),
    .irq      (irq)
  );

  always #10 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic finish_cal;
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #40000;
    error_cnt++;
    test_done();
  end

  initial begin
    do_reset();
    repeat (7) @(posedge clk);
    #1;
    chk(16'(cal_busy), 16'h0);
    @(posedge clk);
    #1;
    chk(16'(cal_busy), 16'h1);
    chk(16'(cal_go), 16'h1);
    finish_cal();
    chk(16'(cal_busy), 16'h0);
    rd_chk(`ACC_A_CAL, 16'h0000);
    wr_reg(`ACC_A_CAL, 16'h0d00);
    chk(16'(cal_go), 16'h0);
    wr_reg(`ACC_A_CAL, 16'h72ff);
    rd_chk(`ACC_A_CAL, 16'h8200);
    wr_reg(`ACC_A_CAL, 16'h0700);
    chk(16'(cal_go), 16'h1);
    chk(16'(cal_diff), 16'h1);
    rd_chk(`ACC_A_CAL, 16'h0700);
    wr_reg(`ACC_A_CAL, 16'h0300);
    chk(16'(cal_go), 16'h0);
    chk(16'(cal_diff), 16'h1);
    finish_cal();
    rd_chk(`ACC_A_CAL, 16'h8600);
    rd_chk(`ACC_A_STS, 16'h0003);
    wr_reg(`ACC_A_MSK, 16'h0003);
    chk(16'(irq), 16'h1);
    wr_reg(`ACC_A_STS, 16'h0003);
    chk(16'(irq), 16'h0);
    rd_chk(2'h3, 16'h0000);
    wr_reg(`ACC_A_CAL, 16'h0300);
    chk(16'(cal_diff), 16'h0);
    finish_cal();
    do_reset();
    wr_reg(`ACC_A_CAL, 16'h0200);
    wr_reg(`ACC_A_CAL, 16'h0a00);
    repeat (12) @(posedge clk);
    #1;
    chk(16'(cal_busy), 16'h0);
    rd_chk(`ACC_A_CAL, 16'h0a00);
    test_done();
  end
endmodule
`default_nettype wire
